// file: core/spcd_pkg.sv
// Constants shared by the serial port control decode block.
// Assumes a 32-bit APB register bus and six serial ports behind it.
`default_nettype none
package spcd_pkg;
	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_CTL0     = 12'h0c00;
	localparam logic [11:0] IDX_CTL1     = 12'h0c01;
	localparam logic [11:0] IDX_CTL2     = 12'h0400;
	localparam logic [11:0] IDX_CTL3     = 12'h0401;
	localparam logic [11:0] IDX_CTL4     = 12'h0800;
	localparam logic [11:0] IDX_CTL5     = 12'h0801;
	localparam logic [11:0] IDX_MC_EN    = 12'h0000;
	// ==========================================================
	// Reset values and storage masks
	localparam logic [31:0] CTL_RESET    = 32'h0000_0000;
	localparam logic [31:0] CTL_WR_MASK  = 32'h020f_ffff;
	localparam logic [11:0] MC_RESET     = 12'h000;
	// ==========================================================
	// Control word field positions
	localparam int B_ENABLE      = 0;
	localparam int B_FMT_LO      = 1;
	localparam int B_BIT_ORDER   = 3;
	localparam int B_LEN_LO      = 4;
	localparam int B_PACK        = 9;
	localparam int B_CLOCK       = 10;
	localparam int B_FAMILY      = 11;
	localparam int B_EDGE        = 12;
	localparam int B_SYNC_REQ    = 13;
	localparam int B_SYNC_INT    = 14;
	localparam int B_SYNC_INDEP  = 15;
	localparam int B_POLARITY    = 16;
	localparam int B_LATE        = 17;
	localparam int B_DMA         = 18;
	localparam int B_CHAIN       = 19;
	localparam int B_DIRECTION   = 25;
	localparam int B_ERROR       = 29;
	localparam int B_STATUS_LO   = 30;
	// ==========================================================
	// Length limits, as word length minus one
	localparam logic [4:0] LEN_MIN_SERIAL = 5'h02;
	localparam logic [4:0] LEN_MIN_AUDIO  = 5'h07;
	// ==========================================================
	// Buffer status codes and the fill level that counts as full
	localparam logic [1:0] STAT_EMPTY   = 2'h0;
	localparam logic [1:0] STAT_PARTIAL = 2'h2;
	localparam logic [1:0] STAT_FULL    = 2'h3;
	localparam logic [1:0] FILL_FULL    = 2'h2;
endpackage
`default_nettype wire

// file: core/spcd_decode.sv
// Six serial port control registers on APB, their mode decode, and
// per-port buffer status and sticky overflow/underflow detection.
// Assumes buffer fill levels come from logic on ref_clk and that the
// serial clocks are asynchronous pins sampled here.
`default_nettype none
module spcd_decode #(
	parameter int NP = 6
) (
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [13:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	input  wire logic [NP-1:0]     link_sclk,
	input  wire logic [2*NP-1:0]   buffer_fill,
	output logic      [NP-1:0]     mode_standard,
	output logic      [NP-1:0]     mode_i2s,
	output logic      [NP-1:0]     mode_left_just,
	output logic      [NP-1:0]     mode_multi_a,
	output logic      [NP-1:0]     mode_multi_b,
	output logic      [NP-1:0]     length_legal,
	output logic      [NP-1:0]     channel_a_enable,
	output logic      [2*NP-1:0]   data_format_select,
	output logic      [NP-1:0]     bit_order_select,
	output logic      [5*NP-1:0]   word_length_field,
	output logic      [NP-1:0]     pack_enable,
	output logic      [NP-1:0]     internal_clock_select,
	output logic      [NP-1:0]     master_select,
	output logic      [NP-1:0]     sample_edge_select,
	output logic      [NP-1:0]     sync_required_select,
	output logic      [NP-1:0]     internal_sync_select,
	output logic      [NP-1:0]     data_independent_sync,
	output logic      [NP-1:0]     sync_polarity_select,
	output logic      [NP-1:0]     channel_order_select,
	output logic      [NP-1:0]     late_sync_select,
	output logic      [NP-1:0]     channel_a_dma_enable,
	output logic      [NP-1:0]     channel_a_chain_enable,
	output logic      [NP-1:0]     direction_select,
	output logic      [2*NP-1:0]   channel_a_buffer_state,
	output logic      [NP-1:0]     channel_a_error_flag
);
	// ==========================================================
	// Register storage
	logic [31:0]     ctl [NP];
	logic [2*NP-1:0] mc_en;
	logic [NP-1:0]   err;
	logic [NP-1:0]   word_end;
	logic [NP-1:0]   sclk_meta;
	logic [NP-1:0]   sclk_sync;
	logic [NP-1:0]   sclk_prev;
	logic [4:0]      bit_cnt [NP];
	logic            hit_ctl;
	logic            hit_mc;
	logic [2:0]      hit_port;
	logic            access_done;
	logic            wr_ctl;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Address decode; unaligned or unknown addresses are unmapped
	always_comb
	begin
		hit_ctl  = 1'b0;
		hit_mc   = 1'b0;
		hit_port = 3'd0;
		if (paddr[1:0] != 2'b00)
			hit_ctl = 1'b0;
		else if (paddr[13:2] == spcd_pkg::IDX_CTL0)
			hit_ctl = 1'b1;
		else if (paddr[13:2] == spcd_pkg::IDX_CTL1)
		begin
			hit_ctl  = 1'b1;
			hit_port = 3'd1;
		end
		else if (paddr[13:2] == spcd_pkg::IDX_CTL2)
		begin
			hit_ctl  = 1'b1;
			hit_port = 3'd2;
		end
		else if (paddr[13:2] == spcd_pkg::IDX_CTL3)
		begin
			hit_ctl  = 1'b1;
			hit_port = 3'd3;
		end
		else if (paddr[13:2] == spcd_pkg::IDX_CTL4)
		begin
			hit_ctl  = 1'b1;
			hit_port = 3'd4;
		end
		else if (paddr[13:2] == spcd_pkg::IDX_CTL5)
		begin
			hit_ctl  = 1'b1;
			hit_port = 3'd5;
		end
		else if (paddr[13:2] == spcd_pkg::IDX_MC_EN)
			hit_mc = 1'b1;
	end

	// Transfer completes at the edge that samples pready high
	assign access_done = psel & penable & pready;
	assign wr_ctl      = access_done & pwrite & hit_ctl;

	// ==========================================================
	// APB answer: one wait state, registered data and error
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~(hit_ctl | hit_mc);
			if (psel & penable & ~pready & ~pwrite & hit_ctl)
				prdata <= (ctl[hit_port] & spcd_pkg::CTL_WR_MASK)
					| ({31'h0000_0000, err[hit_port]} << spcd_pkg::B_ERROR)
					| ({30'h0000_0000, channel_a_buffer_state[2*hit_port +: 2]}
						<< spcd_pkg::B_STATUS_LO);
			else if (psel & penable & ~pready & ~pwrite & hit_mc)
				prdata <= {{(32-2*NP){1'b0}}, mc_en};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Control registers; status and error fields are never stored
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			for (int p = 0; p < NP; p++)
				ctl[p] <= spcd_pkg::CTL_RESET;
			mc_en <= spcd_pkg::MC_RESET[2*NP-1:0];
		end
		else
		begin
			if (wr_ctl)
				ctl[hit_port] <= pwdata & spcd_pkg::CTL_WR_MASK;
			if (access_done & pwrite & hit_mc)
				mc_en <= pwdata[2*NP-1:0];
		end
	end

	// ==========================================================
	// Mode decode; bits that are reserved in a mode drive zero
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mode_standard          <= '0;
			mode_i2s               <= '0;
			mode_left_just         <= '0;
			mode_multi_a           <= '0;
			mode_multi_b           <= '0;
			length_legal           <= '0;
			channel_a_enable       <= '0;
			data_format_select     <= '0;
			bit_order_select       <= '0;
			word_length_field      <= '0;
			pack_enable            <= '0;
			internal_clock_select  <= '0;
			master_select          <= '0;
			sample_edge_select     <= '0;
			sync_required_select   <= '0;
			internal_sync_select   <= '0;
			data_independent_sync  <= '0;
			sync_polarity_select   <= '0;
			channel_order_select   <= '0;
			late_sync_select       <= '0;
			channel_a_dma_enable   <= '0;
			channel_a_chain_enable <= '0;
			direction_select       <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				logic fam;
				logic late;
				logic mc;
				logic std;
				logic [4:0] len;
				fam  = ctl[p][spcd_pkg::B_FAMILY];
				late = ctl[p][spcd_pkg::B_LATE];
				mc   = ~fam & ~late & (mc_en[2*p] | mc_en[2*p+1]);
				std  = ~fam & ~(mc_en[2*p] | mc_en[2*p+1]);
				len  = ctl[p][spcd_pkg::B_LEN_LO +: 5];
				mode_standard[p]  <= std;
				mode_i2s[p]       <= fam & ~late;
				mode_left_just[p] <= fam & late;
				mode_multi_a[p]   <= mc & mc_en[2*p];
				mode_multi_b[p]   <= mc & mc_en[2*p+1];
				length_legal[p]   <= fam ? (len >= spcd_pkg::LEN_MIN_AUDIO)
					: (len >= spcd_pkg::LEN_MIN_SERIAL);
				word_length_field[5*p +: 5] <= len;
				channel_a_enable[p] <= ctl[p][spcd_pkg::B_ENABLE] & ~mc;
				data_format_select[2*p +: 2] <= ctl[p][spcd_pkg::B_FMT_LO +: 2];
				bit_order_select[p] <= ctl[p][spcd_pkg::B_BIT_ORDER] & ~fam;
				pack_enable[p] <= ctl[p][spcd_pkg::B_PACK];
				internal_clock_select[p] <= ctl[p][spcd_pkg::B_CLOCK] & ~fam;
				master_select[p]         <= ctl[p][spcd_pkg::B_CLOCK] & fam;
				sample_edge_select[p] <= ctl[p][spcd_pkg::B_EDGE] & ~fam;
				sync_required_select[p] <= ctl[p][spcd_pkg::B_SYNC_REQ] & std;
				internal_sync_select[p] <= ctl[p][spcd_pkg::B_SYNC_INT] & std;
				data_independent_sync[p] <= ctl[p][spcd_pkg::B_SYNC_INDEP] & ~mc;
				sync_polarity_select[p] <= ctl[p][spcd_pkg::B_POLARITY] & ~fam;
				channel_order_select[p] <= ctl[p][spcd_pkg::B_POLARITY] & fam;
				late_sync_select[p] <= late & ~mc;
				channel_a_dma_enable[p]   <= ctl[p][spcd_pkg::B_DMA];
				channel_a_chain_enable[p] <= ctl[p][spcd_pkg::B_CHAIN];
				direction_select[p]       <= ctl[p][spcd_pkg::B_DIRECTION] & ~mc;
			end
		end
	end

	// ==========================================================
	// Serial clock sampling; edges are found by comparing the second and third stages
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sclk_meta <= '0;
			sclk_sync <= '0;
			sclk_prev <= '0;
		end
		else
		begin
			sclk_meta <= link_sclk;
			sclk_sync <= sclk_meta;
			sclk_prev <= sclk_sync;
		end
	end

	// Word boundary: last bit sampled on the selected edge
	always_comb
	begin
		for (int p = 0; p < NP; p++)
			word_end[p] = (sclk_sync[p] != sclk_prev[p])
				& (sclk_sync[p] == sample_edge_select[p])
				& channel_a_enable[p]
				& (bit_cnt[p] == word_length_field[5*p +: 5]);
	end

	// ==========================================================
	// Bit counters; a port being disabled restarts its word
	always_ff @(posedge ref_clk)
	begin
		for (int p = 0; p < NP; p++)
		begin
			if (sys_rst | ~channel_a_enable[p])
				bit_cnt[p] <= 5'd0;
			else if (word_end[p])
				bit_cnt[p] <= 5'd0;
			else if ((sclk_sync[p] != sclk_prev[p])
				& (sclk_sync[p] == sample_edge_select[p]))
				bit_cnt[p] <= bit_cnt[p] + 5'd1;
		end
	end

	// ==========================================================
	// Buffer status and sticky error; a new error beats the clear
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			channel_a_buffer_state <= '0;
			err                    <= '0;
			channel_a_error_flag   <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				logic set;
				set = word_end[p] & (direction_select[p]
					? (buffer_fill[2*p +: 2] == 2'd0)
					: (buffer_fill[2*p +: 2] >= spcd_pkg::FILL_FULL));
				if (buffer_fill[2*p +: 2] == 2'd0)
					channel_a_buffer_state[2*p +: 2] <= spcd_pkg::STAT_EMPTY;
				else if (buffer_fill[2*p +: 2] >= spcd_pkg::FILL_FULL)
					channel_a_buffer_state[2*p +: 2] <= spcd_pkg::STAT_FULL;
				else
					channel_a_buffer_state[2*p +: 2] <= spcd_pkg::STAT_PARTIAL;
				if (set)
					err[p] <= 1'b1;
				else if (wr_ctl & (hit_port == 3'(p)) & ~pwdata[spcd_pkg::B_ENABLE])
					err[p] <= 1'b0;
			end
			channel_a_error_flag <= err;
		end
	end

	// ==========================================================
	// Checks on port 0 and on the APB answer
	a_i2s_decode: assert property (ctl[0][11] & ~ctl[0][17] |=> mode_i2s[0])
		else $error("i2s not decoded");
	a_lj_decode: assert property (ctl[0][11] & ctl[0][17] |=> mode_left_just[0])
		else $error("left justified not decoded");
	a_std_decode: assert property (~ctl[0][11] & (mc_en[1:0] == 2'b00)
		|=> mode_standard[0] & ~mode_multi_a[0])
		else $error("standard not decoded");
	a_mc_both: assert property (~ctl[0][11] & ~ctl[0][17] & (mc_en[1:0] == 2'b11)
		|=> mode_multi_a[0] & mode_multi_b[0] & ~channel_a_enable[0])
		else $error("multichannel both not decoded");
	a_enable_bit: assert property (mode_standard[0] & $rose(channel_a_enable[0])
		|-> $past(ctl[0][0]))
		else $error("enable without bit");
	a_order_reserved: assert property (mode_i2s[0] |-> ~bit_order_select[0]
		& ~sample_edge_select[0] & ~sync_required_select[0])
		else $error("reserved bit leaked in i2s");
	a_len_legal: assert property (mode_i2s[0] & (word_length_field[4:0] == 5'd6)
		|-> ~length_legal[0])
		else $error("short i2s word accepted");
	a_master_sel: assert property (ctl[0][10] & ctl[0][11]
		|=> master_select[0] & ~internal_clock_select[0])
		else $error("master not decoded");
	a_ro_write: assert property (wr_ctl & (hit_port == 3'd0)
		|=> (ctl[0][31:26] == 6'd0) & (ctl[0][24:20] == 5'd0))
		else $error("read-only bits stored");
	a_reserved_zero: assert property (access_done & ~pwrite
		|-> (prdata[28:26] == 3'd0) & (prdata[24:20] == 5'd0))
		else $error("reserved bits read nonzero");
	a_err_sticky: assert property (err[0] & ~(wr_ctl & (hit_port == 3'd0))
		|=> err[0])
		else $error("error flag not sticky");
	a_err_set: assert property (word_end[0] & direction_select[0]
		& (buffer_fill[1:0] == 2'd0) |=> ##1 channel_a_error_flag[0])
		else $error("underflow missed");
	a_status_full: assert property (buffer_fill[1:0] == 2'd3
		|=> channel_a_buffer_state[1:0] == 2'b11)
		else $error("full status wrong");
	a_apb_wait: assert property (psel & penable & ~pready |=> pready ##1 ~pready)
		else $error("apb answer timing");
	c_write_read: cover property (wr_ctl ##[1:8] (access_done & ~pwrite & hit_ctl));
	c_overflow: cover property (word_end[0] & ~direction_select[0] ##2 channel_a_error_flag[0]);
	c_mode_lj: cover property (mode_left_just[0] & channel_order_select[0]);
endmodule
`default_nettype wire

// file: tb/spcd_peer.sv
// Serial peer model: drives the link clock of the far side.
// Assumes the bench calls burst while the port is set up.
`default_nettype none
module spcd_peer (
	output logic sclk
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Clock stands low between frames, never free running
	initial sclk = 1'b0;
	task automatic burst(input int n);
		#33;
		repeat (n)
		begin
			#40 sclk = 1'b1;
			#40 sclk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench for the serial port control decode block over APB.
// Assumes the peer model makes one link clock shared by all ports.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Design signals
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [11:0] buffer_fill = 12'h000;
	logic        pready, pslverr, sclk, err;
	logic [31:0] prdata, rd;
	logic [5:0]  link_sclk;
	logic [5:0]  mode_standard, mode_i2s, mode_left_just, mode_multi_a, mode_multi_b;
	logic [5:0]  length_legal, channel_a_enable, bit_order_select, pack_enable;
	logic [5:0]  internal_clock_select, master_select, sample_edge_select;
	logic [5:0]  sync_required_select, internal_sync_select, data_independent_sync;
	logic [5:0]  sync_polarity_select, channel_order_select, late_sync_select;
	logic [5:0]  channel_a_dma_enable, channel_a_chain_enable, direction_select;
	logic [5:0]  channel_a_error_flag;
	logic [11:0] data_format_select, channel_a_buffer_state;
	logic [29:0] word_length_field;
	int          n_fail = 0;
	int          checks_done = 0;
	logic [11:0] idx_tab [6] = '{spcd_pkg::IDX_CTL0, spcd_pkg::IDX_CTL1, spcd_pkg::IDX_CTL2,
		spcd_pkg::IDX_CTL3, spcd_pkg::IDX_CTL4, spcd_pkg::IDX_CTL5};
	// ==========================================================
	// Clock, link and instances
	always #5 ref_clk = ~ref_clk;
	assign link_sclk = {6{sclk}};
	spcd_decode DUT (
		.ref_clk                (ref_clk),
		.sys_rst                (sys_rst),
		.psel                   (psel),
		.penable                (penable),
		.pwrite                 (pwrite),
		.paddr                  (paddr),
		.pwdata                 (pwdata),
		.pready                 (pready),
		.prdata                 (prdata),
		.pslverr                (pslverr),
		.link_sclk              (link_sclk),
		.buffer_fill            (buffer_fill),
		.mode_standard          (mode_standard),
		.mode_i2s               (mode_i2s),
		.mode_left_just         (mode_left_just),
		.mode_multi_a           (mode_multi_a),
		.mode_multi_b           (mode_multi_b),
		.length_legal           (length_legal),
		.channel_a_enable       (channel_a_enable),
		.data_format_select     (data_format_select),
		.bit_order_select       (bit_order_select),
		.word_length_field      (word_length_field),
		.pack_enable            (pack_enable),
		.internal_clock_select  (internal_clock_select),
		.master_select          (master_select),
		.sample_edge_select     (sample_edge_select),
		.sync_required_select   (sync_required_select),
		.internal_sync_select   (internal_sync_select),
		.data_independent_sync  (data_independent_sync),
		.sync_polarity_select   (sync_polarity_select),
		.channel_order_select   (channel_order_select),
		.late_sync_select       (late_sync_select),
		.channel_a_dma_enable   (channel_a_dma_enable),
		.channel_a_chain_enable (channel_a_chain_enable),
		.direction_select       (direction_select),
		.channel_a_buffer_state (channel_a_buffer_state),
		.channel_a_error_flag   (channel_a_error_flag)
	);
	spcd_peer peer (.sclk(sclk));
	// ==========================================================
	// Shared tasks
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	// Request held until pready is seen high, so no fixed latency assumed
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
		int i;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 50);
		if (i >= 50)
		begin
			n_fail++;
			close_out();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset_map();
		apb(1'b0, spcd_pkg::IDX_MC_EN, 32'h0);
		chk("mc reset", {20'h0, spcd_pkg::MC_RESET}, rd);
		for (int p = 0; p < 6; p++)
		begin
			apb(1'b0, idx_tab[p], 32'h0);
			chk("ctl reset", spcd_pkg::CTL_RESET, rd);
			apb(1'b1, idx_tab[p], 32'hFFFF_FFFF);
			apb(1'b0, idx_tab[p], 32'h0);
			chk("ctl mask", spcd_pkg::CTL_WR_MASK, rd);
			apb(1'b1, idx_tab[p], 32'h0);
		end
	endtask
	task automatic t_unmapped();
		apb(1'b1, 12'h002, 32'hFFFF_FFFF);
		chk("slverr wr", 32'h1, {31'h0, err});
		apb(1'b0, 12'h002, 32'h0);
		chk("unmapped rd", 32'h0, rd);
	endtask
	task automatic t_modes();
		logic [31:0] ctl [8] = '{32'h0000_0021, 32'h0000_0871, 32'h0002_0871,
			32'h0000_0861, 32'h0000_0021, 32'h0000_0021, 32'h0000_0021, 32'h0000_0011};
		logic [1:0] mc [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
		logic [4:0] md [8] = '{5'h10, 5'h08, 5'h04, 5'h08, 5'h02, 5'h01, 5'h03, 5'h10};
		logic [7:0] lg = 8'b0111_0111;
		logic [4:0] got;
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b1, spcd_pkg::IDX_MC_EN, {30'h0, mc[k]});
			apb(1'b1, spcd_pkg::IDX_CTL0, ctl[k]);
			repeat (3) @(posedge ref_clk);
			got = {mode_standard[0], mode_i2s[0], mode_left_just[0], mode_multi_a[0],
				mode_multi_b[0]};
			chk("mode", {27'h0, md[k]}, {27'h0, got});
			chk("legal", {31'h0, lg[k]}, {31'h0, length_legal[0]});
			chk("enable", {31'h0, mc[k] == 2'h0}, {31'h0, channel_a_enable[0]});
		end
	endtask
	task automatic t_fields();
		logic [31:0] w;
		w = 32'h020F_F7FF;
		apb(1'b1, spcd_pkg::IDX_MC_EN, 32'h0);
		apb(1'b1, spcd_pkg::IDX_CTL0, w);
		repeat (3) @(posedge ref_clk);
		chk("fields", {13'h0, w[25], w[19:12], w[10:9], w[8:4], w[3], w[2:1]},
			{13'h0, direction_select[0], channel_a_chain_enable[0], channel_a_dma_enable[0],
			late_sync_select[0], sync_polarity_select[0], data_independent_sync[0],
			internal_sync_select[0], sync_required_select[0], sample_edge_select[0],
			internal_clock_select[0], pack_enable[0], word_length_field[4:0],
			bit_order_select[0], data_format_select[1:0]});
		apb(1'b1, spcd_pkg::IDX_CTL0, 32'h000B_FFFF);
		repeat (3) @(posedge ref_clk);
		chk("audio", 32'hC0, {24'h0, master_select[0], channel_order_select[0],
			internal_clock_select[0], bit_order_select[0], sample_edge_select[0],
			sync_required_select[0], internal_sync_select[0],
			sync_polarity_select[0]});
		apb(1'b1, spcd_pkg::IDX_MC_EN, 32'h1);
		// Late sync must stay clear, otherwise the port is not multichannel at all
		apb(1'b1, spcd_pkg::IDX_CTL0, 32'h0201_E021);
		repeat (3) @(posedge ref_clk);
		chk("multi mode", 32'h1, {31'h0, mode_multi_a[0]});
		chk("multi", 32'h0, {26'h0, channel_a_enable[0], sync_required_select[0],
			internal_sync_select[0], data_independent_sync[0], late_sync_select[0],
			direction_select[0]});
		apb(1'b1, spcd_pkg::IDX_MC_EN, 32'h0);
		apb(1'b1, spcd_pkg::IDX_CTL0, 32'h0);
	endtask
	task automatic t_status();
		// A fill count of two already means a full two-word buffer
		logic [1:0] st [4] = '{2'h0, 2'h2, 2'h3, 2'h3};
		for (int f = 0; f < 4; f++)
		begin
			buffer_fill <= {6{f[1:0]}};
			repeat (3) @(posedge ref_clk);
			chk("state", {20'h0, {6{st[f]}}}, {20'h0, channel_a_buffer_state});
			apb(1'b0, spcd_pkg::IDX_CTL5, 32'h0);
			chk("state rd", {st[f], 30'h0}, rd);
		end
	endtask
	task automatic t_error();
		buffer_fill <= 12'h000;
		apb(1'b1, spcd_pkg::IDX_CTL0, 32'h0200_1021);
		peer.burst(8);
		repeat (10) @(posedge ref_clk);
		chk("underflow", 32'h1, {31'h0, channel_a_error_flag[0]});
		apb(1'b0, spcd_pkg::IDX_CTL0, 32'h0);
		chk("err rd", 32'h2200_1021, rd);
		buffer_fill <= 12'h001;
		repeat (5) @(posedge ref_clk);
		chk("sticky", 32'h1, {31'h0, channel_a_error_flag[0]});
		apb(1'b1, spcd_pkg::IDX_CTL0, 32'h0000_1020);
		repeat (3) @(posedge ref_clk);
		chk("err clear", 32'h0, {31'h0, channel_a_error_flag[0]});
		buffer_fill <= 12'h002;
		apb(1'b1, spcd_pkg::IDX_CTL0, 32'h0000_1021);
		peer.burst(8);
		repeat (10) @(posedge ref_clk);
		chk("overflow", 32'h1, {31'h0, channel_a_error_flag[0]});
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset_map();
		t_unmapped();
		t_modes();
		t_fields();
		t_status();
		t_error();
		close_out();
	end
endmodule
`default_nettype wire
